// ---- hw/slor_pkg.sv ----
// Package for the lane override register bank: offsets, fields, resets, timing
package slor_pkg;

    localparam logic [11:0] SLOR_TX_OVR_OFFSET   = 12'h004;
    localparam logic [11:0] SLOR_RX_OVR_OFFSET   = 12'h008;

    // Transmit override and output status register fields
    localparam int SLOR_TX_EN_BIT      = 31;
    localparam int SLOR_TX_BOOST_LSB   = 22;
    localparam int SLOR_TX_BOOST_MSB   = 25;
    localparam int SLOR_TX_RSV_LSB     = 26;
    localparam int SLOR_TX_RSV_MSB     = 30;
    localparam int SLOR_TX_PRES_LSB    = 3;
    localparam int SLOR_TX_PRES_MSB    = 21;
    localparam int SLOR_SIG_ABSENT_BIT = 2;

    // Receive override register fields
    localparam int SLOR_RX_EN_BIT      = 14;
    localparam int SLOR_SQ_LSB         = 12;
    localparam int SLOR_SQ_MSB         = 13;
    localparam int SLOR_RX_EQ_LSB      = 5;
    localparam int SLOR_RX_EQ_MSB      = 7;
    localparam int SLOR_ALIGN_BIT      = 3;
    localparam int SLOR_HALF_RATE_BIT  = 0;

    // Reset values
    localparam logic       SLOR_TX_EN_RST      = 1'b0;
    localparam logic [3:0] SLOR_TX_BOOST_RST   = 4'h0;
    localparam logic [4:0] SLOR_TX_RSV_RST     = 5'h00;
    localparam logic       SLOR_RX_EN_RST      = 1'b0;
    localparam logic [1:0] SLOR_SQ_RST         = 2'h1;
    localparam logic [2:0] SLOR_RX_EQ_RST      = 3'h0;
    localparam logic       SLOR_ALIGN_RST      = 1'b1;
    localparam logic       SLOR_HALF_RATE_RST  = 1'b0;
    localparam logic [3:0] SLOR_RX_PRES_LO_RST = 4'hf; // Rx bits 4:1; index 2 is the align slot
    localparam logic [1:0] SLOR_SQ_HEAVY       = 2'h3;
    localparam logic [1:0] SLOR_SQ_OFF         = 2'h0;

    // Heavy filter: 128 +/- 5 prescaler cycles without signal
    localparam int         SLOR_SQ_HEAVY_CYCLES = 128;
    localparam logic [7:0] SLOR_SQ_HEAVY_COUNT  = 8'(SLOR_SQ_HEAVY_CYCLES - 1);

    typedef struct packed {
        logic       tx_override_enable;
        logic [3:0] tx_boost;
    } slor_tx_ctl_s;

    typedef struct packed {
        logic       rx_override_enable;
        logic [1:0] squelch_filter_select;
        logic [2:0] receive_equalizer_level;
        logic       align_enable;
        logic       half_rate;
    } slor_rx_ctl_s;

endpackage

// ---- hw/slor_regs.sv ----
// Lane override register bank with APB slave and lane control selection
//
// The APB register port was decided locally.
`timescale 1ns/1ps

// Operation
// - Bit 31 of the transmit register enables override of its bits 16 to 30 and resets to 0.
// - Transmit boost at bits 25:22 is read-write, resets to 0, and code 0 means no boost.
// - Bit 2 of the transmit register reads the lane signal-absent output and ignores writes.
// - Bit 14 of the receive register enables override of its bits 0 to 13 and resets to 0.
// - Squelch filter select at bits 13:12 resets to 01; 00 off, 11 heavy, 01 and 10 reserved.
// - Heavy filtering flags signal absence after 128 +/- 5 prescaler cycles without signal.
// - Receive equalizer level at bits 7:5 resets to 000 and sets boost in half-decibel steps.
// - Bit 3 of the receive register enables word alignment and resets to 1.
// - Bit 0 of the receive register is half-rate control, resets to 0, used under override.
// - Fields without a fixed reset, in both registers, come from power-up inputs.
// - With an override set, the default status no longer shows the applied controls.
module slor_regs
    import slor_pkg::*;
(
    input  wire logic         clk_in,
    input  wire logic         rst_b_in,
    input  wire logic         psel_in,
    input  wire logic         penable_in,
    input  wire logic         pwrite_in,
    input  wire logic [11:0]  paddr_in,
    input  wire logic [31:0]  pwdata_in,
    output logic      [31:0]  prdata_out,
    output logic              pready_out,
    output logic              pslverr_out,
    input  wire logic         presc_clk_in,
    input  wire logic         signal_present_in,
    input  wire slor_tx_ctl_s tx_default_in,
    input  wire slor_rx_ctl_s rx_default_in,
    input  wire logic [18:0]  tx_preserved_default_in,
    input  wire logic [1:0]   tx_low_default_in,
    input  wire logic [16:0]  rx_preserved_hi_default_in,
    input  wire logic [3:0]   rx_preserved_mid_default_in,
    output slor_tx_ctl_s      tx_applied_out,
    output slor_rx_ctl_s      rx_applied_out,
    output logic              signal_absent_flag_out
);

    logic        rst_meta_reg;
    logic        rst_sync_reg;
    logic        rst_b;

    slor_tx_ctl_s tx_ovr_reg;
    logic [4:0]  tx_rsv_reg;
    logic [18:0] tx_pres_reg;
    logic [1:0]  tx_low_reg;
    slor_rx_ctl_s rx_ovr_reg;
    logic [16:0] rx_pres_hi_reg;
    logic [3:0]  rx_pres_mid_reg;
    logic        rx_pres_b4_reg;
    logic [1:0]  rx_pres_b21_reg;
    logic        strap_done_reg;

    logic        wr_strobe;
    logic        hit_tx;
    logic        hit_rx;
    slor_tx_ctl_s tx_applied_next;
    slor_rx_ctl_s rx_applied_next;

    // Reset release through two stages
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_b = rst_sync_reg;

    // APB: zero wait states; unmapped addresses answer with an error
    assign hit_tx      = (paddr_in == SLOR_TX_OVR_OFFSET);
    assign hit_rx      = (paddr_in == SLOR_RX_OVR_OFFSET);
    assign pready_out  = 1'b1;
    assign pslverr_out = psel_in && penable_in && !(hit_tx || hit_rx);
    assign wr_strobe   = psel_in && penable_in && pwrite_in;

    always_comb
    begin
        prdata_out = 32'h0000_0000;
        if (hit_tx)
        begin
            prdata_out[SLOR_TX_EN_BIT]                        = tx_ovr_reg.tx_override_enable;
            prdata_out[SLOR_TX_RSV_MSB:SLOR_TX_RSV_LSB]       = tx_rsv_reg;
            prdata_out[SLOR_TX_BOOST_MSB:SLOR_TX_BOOST_LSB]   = tx_ovr_reg.tx_boost;
            prdata_out[SLOR_TX_PRES_MSB:SLOR_TX_PRES_LSB]     = tx_pres_reg;
            prdata_out[SLOR_SIG_ABSENT_BIT]                   = signal_absent_flag_out;
            prdata_out[1:0]                                   = tx_low_reg;
        end
        else if (hit_rx)
        begin
            prdata_out[31:15]                                 = rx_pres_hi_reg;
            prdata_out[SLOR_RX_EN_BIT]                        = rx_ovr_reg.rx_override_enable;
            prdata_out[SLOR_SQ_MSB:SLOR_SQ_LSB]               = rx_ovr_reg.squelch_filter_select;
            prdata_out[11:8]                                  = rx_pres_mid_reg;
            prdata_out[SLOR_RX_EQ_MSB:SLOR_RX_EQ_LSB]         = rx_ovr_reg.receive_equalizer_level;
            prdata_out[4]                                     = rx_pres_b4_reg;
            prdata_out[SLOR_ALIGN_BIT]                        = rx_ovr_reg.align_enable;
            prdata_out[2:1]                                   = rx_pres_b21_reg;
            prdata_out[SLOR_HALF_RATE_BIT]                    = rx_ovr_reg.half_rate;
        end
    end

    // Transmit override fields
    always_ff @(posedge clk_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_ovr_reg.tx_override_enable <= SLOR_TX_EN_RST;
            tx_ovr_reg.tx_boost           <= SLOR_TX_BOOST_RST;
            tx_rsv_reg                    <= SLOR_TX_RSV_RST;
        end
        else if (wr_strobe && hit_tx)
        begin
            tx_ovr_reg.tx_override_enable <= pwdata_in[SLOR_TX_EN_BIT];
            tx_ovr_reg.tx_boost           <= pwdata_in[SLOR_TX_BOOST_MSB:SLOR_TX_BOOST_LSB];
            tx_rsv_reg                    <= pwdata_in[SLOR_TX_RSV_MSB:SLOR_TX_RSV_LSB];
        end
    end

    // Undefined-at-reset fields catch power-up inputs once after release
    always_ff @(posedge clk_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            strap_done_reg <= 1'b0;
        end
        else
        begin
            strap_done_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!strap_done_reg)
        begin
            tx_pres_reg     <= tx_preserved_default_in;
            tx_low_reg      <= tx_low_default_in;
            rx_pres_hi_reg  <= rx_preserved_hi_default_in;
            rx_pres_mid_reg <= rx_preserved_mid_default_in;
        end
        else if (wr_strobe && hit_tx)
        begin
            tx_pres_reg <= pwdata_in[SLOR_TX_PRES_MSB:SLOR_TX_PRES_LSB];
        end
        else if (wr_strobe && hit_rx)
        begin
            rx_pres_mid_reg <= pwdata_in[11:8];
        end
    end

    // Receive override fields; bits 31:15 read-only
    always_ff @(posedge clk_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_ovr_reg.rx_override_enable      <= SLOR_RX_EN_RST;
            rx_ovr_reg.squelch_filter_select   <= SLOR_SQ_RST;
            rx_ovr_reg.receive_equalizer_level <= SLOR_RX_EQ_RST;
            rx_ovr_reg.align_enable            <= SLOR_ALIGN_RST;
            rx_ovr_reg.half_rate               <= SLOR_HALF_RATE_RST;
            rx_pres_b4_reg                     <= SLOR_RX_PRES_LO_RST[3];
            rx_pres_b21_reg                    <= SLOR_RX_PRES_LO_RST[1:0];
        end
        else if (wr_strobe && hit_rx)
        begin
            rx_ovr_reg.rx_override_enable      <= pwdata_in[SLOR_RX_EN_BIT];
            rx_ovr_reg.squelch_filter_select   <= pwdata_in[SLOR_SQ_MSB:SLOR_SQ_LSB];
            rx_ovr_reg.receive_equalizer_level <= pwdata_in[SLOR_RX_EQ_MSB:SLOR_RX_EQ_LSB];
            rx_ovr_reg.align_enable            <= pwdata_in[SLOR_ALIGN_BIT];
            rx_ovr_reg.half_rate               <= pwdata_in[SLOR_HALF_RATE_BIT];
            rx_pres_b4_reg                     <= pwdata_in[4];
            rx_pres_b21_reg                    <= pwdata_in[2:1];
        end
    end

    // Override selection; the default status stays untouched while overridden
    always_comb
    begin
        tx_applied_next = tx_default_in;
        rx_applied_next = rx_default_in;
        tx_applied_next.tx_override_enable = tx_ovr_reg.tx_override_enable;
        rx_applied_next.rx_override_enable = rx_ovr_reg.rx_override_enable;
        if (tx_ovr_reg.tx_override_enable)
        begin
            tx_applied_next.tx_boost = tx_ovr_reg.tx_boost;
        end
        if (rx_ovr_reg.rx_override_enable)
        begin
            rx_applied_next = rx_ovr_reg;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_applied_out <= '0;
            rx_applied_out <= '0;
        end
        else
        begin
            tx_applied_out <= tx_applied_next;
            rx_applied_out <= rx_applied_next;
        end
    end

    // Squelch filter on the prescaler clock; absence count is a best effort of 128
    logic [7:0]  sq_cnt_reg;
    logic        sq_abs_reg;
    logic        sq_meta_reg;
    logic        sq_sync_reg;
    logic        sq_heavy_meta_reg;
    logic        sq_heavy_sync_reg;

    // Only the heavy decision crosses; reserved codes act as off, so no word crossing
    always_ff @(posedge presc_clk_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sq_heavy_meta_reg <= 1'b0;
            sq_heavy_sync_reg <= 1'b0;
        end
        else
        begin
            sq_heavy_meta_reg <= (rx_applied_out.squelch_filter_select == SLOR_SQ_HEAVY);
            sq_heavy_sync_reg <= sq_heavy_meta_reg;
        end
    end

    always_ff @(posedge presc_clk_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sq_cnt_reg <= 8'h00;
            sq_abs_reg <= 1'b0;
        end
        else if (signal_present_in)
        begin
            sq_cnt_reg <= 8'h00;
            sq_abs_reg <= 1'b0;
        end
        else if (!sq_heavy_sync_reg)
        begin
            sq_cnt_reg <= 8'h00;
            sq_abs_reg <= 1'b1;
        end
        else if (sq_cnt_reg == SLOR_SQ_HEAVY_COUNT)
        begin
            sq_abs_reg <= 1'b1;
        end
        else
        begin
            sq_cnt_reg <= sq_cnt_reg + 8'h01;
        end
    end

    // Flag is synchronous to the prescaler; resynchronised for the bus side
    always_ff @(posedge clk_in or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sq_meta_reg <= 1'b0;
            sq_sync_reg <= 1'b0;
        end
        else
        begin
            sq_meta_reg <= sq_abs_reg;
            sq_sync_reg <= sq_meta_reg;
        end
    end
    assign signal_absent_flag_out = sq_sync_reg;

    property p_tx_boost_apply;
        @(posedge clk_in) disable iff (!rst_b)
        tx_ovr_reg.tx_override_enable |=> tx_applied_out.tx_boost == $past(tx_ovr_reg.tx_boost);
    endproperty
    a_tx_boost_apply: assert property (p_tx_boost_apply) else $error("tx boost not applied");

    property p_tx_default;
        @(posedge clk_in) disable iff (!rst_b)
        !tx_ovr_reg.tx_override_enable |=> tx_applied_out.tx_boost == $past(tx_default_in.tx_boost);
    endproperty
    a_tx_default: assert property (p_tx_default) else $error("tx default not used");

    property p_rx_apply;
        @(posedge clk_in) disable iff (!rst_b)
        rx_ovr_reg.rx_override_enable |=> rx_applied_out == $past(rx_ovr_reg);
    endproperty
    a_rx_apply: assert property (p_rx_apply) else $error("rx override not applied");

    property p_absent_ro;
        @(posedge clk_in) disable iff (!rst_b)
        (psel_in && penable_in && hit_tx && !pwrite_in)
            |-> prdata_out[SLOR_SIG_ABSENT_BIT] == $past(sq_abs_reg, 2);
    endproperty
    a_absent_ro: assert property (p_absent_ro) else $error("absent bit wrong");

    property p_heavy_wait;
        @(posedge presc_clk_in) disable iff (!rst_b)
        $rose(sq_abs_reg) && $past(sq_heavy_sync_reg)
            |-> $past(sq_cnt_reg) == SLOR_SQ_HEAVY_COUNT;
    endproperty
    a_heavy_wait: assert property (p_heavy_wait) else $error("early absence flag");

    property p_sq_direct;
        @(posedge presc_clk_in) disable iff (!rst_b)
        (!signal_present_in && !sq_heavy_sync_reg) |=> sq_abs_reg;
    endproperty
    a_sq_direct: assert property (p_sq_direct) else $error("unfiltered absence late");

    property p_sq_clear;
        @(posedge presc_clk_in) disable iff (!rst_b)
        signal_present_in |=> !sq_abs_reg;
    endproperty
    a_sq_clear: assert property (p_sq_clear) else $error("absence flag stuck");

    property p_wr_eq;
        @(posedge clk_in) disable iff (!rst_b)
        (wr_strobe && hit_rx) |=> rx_ovr_reg.receive_equalizer_level == $past(pwdata_in[7:5]);
    endproperty
    a_wr_eq: assert property (p_wr_eq) else $error("eq write lost");

    property p_align_wr;
        @(posedge clk_in) disable iff (!rst_b)
        (wr_strobe && hit_rx) |=> rx_ovr_reg.align_enable == $past(pwdata_in[3]);
    endproperty
    a_align_wr: assert property (p_align_wr) else $error("align write lost");

    property p_half_rate;
        @(posedge clk_in) disable iff (!rst_b)
        rx_ovr_reg.rx_override_enable |=> rx_applied_out.half_rate == $past(rx_ovr_reg.half_rate);
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("half rate not applied");

    c_tx_ovr: cover property (@(posedge clk_in) disable iff (!rst_b)
        $rose(tx_ovr_reg.tx_override_enable));
    c_rx_ovr: cover property (@(posedge clk_in) disable iff (!rst_b)
        $rose(rx_ovr_reg.rx_override_enable));
    c_absent: cover property (@(posedge clk_in) disable iff (!rst_b)
        $rose(signal_absent_flag_out));
    c_heavy: cover property (@(posedge presc_clk_in) disable iff (!rst_b)
        $rose(sq_abs_reg) && $past(sq_heavy_sync_reg));
    c_bus_err: cover property (@(posedge clk_in) disable iff (!rst_b) pslverr_out);

endmodule

// ---- dv/slor_lane_model.sv ----
// Behavioural lane front end: prescaler clock, signal detect, control sink
`timescale 1ns/1ps
module slor_lane_model
    import slor_pkg::*;
#(
    parameter int PRESC_HALF_NS = 30
)
(
    input  wire logic         lose_signal_in,
    input  wire slor_tx_ctl_s tx_applied_in,
    input  wire slor_rx_ctl_s rx_applied_in,
    output logic              presc_clk_out,
    output logic              signal_present_out
);
    slor_tx_ctl_s tx_seen_reg;
    slor_rx_ctl_s rx_seen_reg;

    initial
    begin
        presc_clk_out = 1'b0;
        signal_present_out = 1'b1;
    end

    // Runs free and unrelated to the register clock
    always #(PRESC_HALF_NS) presc_clk_out = ~presc_clk_out;

    // Line state moves only on prescaler edges, as the detector expects
    always @(posedge presc_clk_out)
        signal_present_out <= ~lose_signal_in;

    // Front end simply takes the controls; analogue effect not modelled
    always @(posedge presc_clk_out)
    begin
        tx_seen_reg <= tx_applied_in;
        rx_seen_reg <= rx_applied_in;
    end
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the lane override register bank
`timescale 1ns/1ps
module tb_top
    import slor_pkg::*;
;
    typedef struct packed {
        logic [31:0] data;
        logic [31:0] mask;
        logic        err;
    } slor_tb_exp_s;

    logic         clk_in = 1'b0;
    logic         rst_b_in;
    logic         psel_in;
    logic         penable_in;
    logic         pwrite_in;
    logic [11:0]  paddr_in;
    logic [31:0]  pwdata_in;
    logic [31:0]  prdata_out;
    logic         pready_out;
    logic         pslverr_out;
    logic         presc_clk_in;
    logic         signal_present_in;
    logic         signal_absent_flag_out;
    logic         lose_sig;
    slor_tx_ctl_s tx_default_in;
    slor_tx_ctl_s tx_applied_out;
    slor_rx_ctl_s rx_default_in;
    slor_rx_ctl_s rx_applied_out;
    logic [18:0]  tx_pres;
    logic [1:0]   tx_low;
    logic [16:0]  rx_hi;
    logic [3:0]   rx_mid;
    logic [31:0]  tx_exp;
    logic [31:0]  rx_exp;
    logic [31:0]  d;
    slor_tb_exp_s exp_q[$];
    slor_tb_exp_s mon_e;
    int           fails = 0;
    int           checks = 0;
    int           cycles = 0;
    int           seed = 79;
    int           n;

    slor_regs dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .presc_clk_in(presc_clk_in),
        .signal_present_in(signal_present_in), .tx_default_in(tx_default_in),
        .rx_default_in(rx_default_in), .tx_preserved_default_in(tx_pres),
        .tx_low_default_in(tx_low), .rx_preserved_hi_default_in(rx_hi),
        .rx_preserved_mid_default_in(rx_mid), .tx_applied_out(tx_applied_out),
        .rx_applied_out(rx_applied_out), .signal_absent_flag_out(signal_absent_flag_out));

    slor_lane_model lane (.lose_signal_in(lose_sig), .tx_applied_in(tx_applied_out),
        .rx_applied_in(rx_applied_out), .presc_clk_out(presc_clk_in),
        .signal_present_out(signal_present_in));

    always #12.5 clk_in = ~clk_in;

    task end_of_test;
        $display("Checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task cmp32(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        checks++;
        if ((got & m) !== (exp & m))
        begin
            fails++;
            $display("Error %0t: got %h expected %h mask %h", $time, got, exp, m);
        end
    endtask

    task cmp_rng(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi)
        begin
            fails++;
            $display("Error %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    // Ends one idle edge after release so psel never changes twice at one edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
             input logic [31:0] ed, input logic [31:0] m);
        exp_q.push_back('{data: ed, mask: m, err: (a != 12'h004 && a != 12'h008)});
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= wd;
        @(posedge clk_in);
        penable_in <= 1'b1;
        @(posedge clk_in);
        while (pready_out !== 1'b1)
            @(posedge clk_in);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask

    task chk_app;
        logic [3:0]   tb;
        slor_rx_ctl_s er;
        tb = tx_exp[31] ? tx_exp[25:22] : tx_default_in.tx_boost;
        er = rx_exp[14] ? {1'b0, rx_exp[13:12], rx_exp[7:5], rx_exp[3], rx_exp[0]}
                        : rx_default_in;
        cmp32({28'h0, tx_applied_out.tx_boost}, {28'h0, tb}, 32'hf);
        cmp32({24'h0, rx_applied_out}, {24'h0, er}, 32'h7f);
    endtask

    always @(posedge clk_in)
        if (psel_in && penable_in && pready_out === 1'b1 && exp_q.size() > 0)
        begin
            mon_e = exp_q.pop_front();
            cmp32(prdata_out, mon_e.data, mon_e.mask);
            cmp32({31'h0, pslverr_out}, {31'h0, mon_e.err}, 32'h1);
        end

    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            $display("Error %0t: timeout", $time);
            end_of_test();
        end
    end

    initial
    begin
        rst_b_in = 1'b0;
        psel_in = 1'b0;
        penable_in = 1'b0;
        pwrite_in = 1'b0;
        paddr_in = 12'h000;
        pwdata_in = 32'h0;
        lose_sig = 1'b0;
        tx_default_in = 5'($random(seed));
        rx_default_in = 8'($random(seed));
        rx_default_in.squelch_filter_select = 2'h0;
        tx_pres = 19'($random(seed));
        tx_low = 2'($random(seed));
        rx_hi = 17'($random(seed));
        rx_mid = 4'($random(seed));
        repeat (5) @(posedge clk_in);
        rst_b_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        tx_exp = {1'b0, 5'h00, 4'h0, tx_pres, 1'b0, tx_low};
        rx_exp = {rx_hi, 1'b0, 2'h1, rx_mid, 3'h0, 1'b1, 1'b1, 2'h3, 1'b0};
        apb(1'b0, 12'h004, 32'h0, tx_exp, 32'hffffffff);
        apb(1'b0, 12'h008, 32'h0, rx_exp, 32'hffffffff);
        chk_app();
        // Unmapped places, including the left-out default status word
        apb(1'b1, 12'h000, 32'hffffffff, 32'h0, 32'h0);
        apb(1'b0, 12'h000, 32'h0, 32'h0, 32'hffffffff);
        apb(1'b1, 12'h00c, 32'hffffffff, 32'h0, 32'h0);
        apb(1'b0, 12'h00c, 32'h0, 32'h0, 32'hffffffff);
        for (int i = 0; i < 6; i++)
        begin
            d = $random(seed);
            d[31] = i[0];
            d[21:3] = tx_exp[21:3];
            if (i == 3)
                d[25:22] = 4'h0;
            apb(1'b1, 12'h004, d, 32'h0, 32'h0);
            tx_exp = {d[31:3], tx_exp[2:0]};
            d = $random(seed);
            d[14] = i[0];
            d[13:12] = {2{d[12]}};
            d[11:8] = rx_exp[11:8];
            d[4] = rx_exp[4];
            d[2:1] = rx_exp[2:1];
            apb(1'b1, 12'h008, d, 32'h0, 32'h0);
            rx_exp = {rx_exp[31:15], d[14:0]};
            apb(1'b0, 12'h004, 32'h0, tx_exp, 32'hffffffff);
            apb(1'b0, 12'h008, 32'h0, rx_exp, 32'hffffffff);
            repeat (3) @(posedge clk_in);
            chk_app();
        end
        for (int c = 0; c < 2; c++)
        begin
            rx_exp[14:12] = {1'b1, {2{c[0]}}};
            apb(1'b1, 12'h008, rx_exp, 32'h0, 32'h0);
            repeat (3) @(posedge clk_in);
            @(posedge presc_clk_in);
            lose_sig <= 1'b1;
            n = 0;
            while (signal_absent_flag_out !== 1'b1 && n < 400)
            begin
                @(posedge presc_clk_in);
                n++;
            end
            if (c == 1)
                cmp_rng(n, 124, 135);
            else
                cmp_rng(n, 1, 3);
            @(posedge clk_in);
            apb(1'b1, 12'h004, {tx_exp[31:3], 3'h0}, 32'h0, 32'h0);
            apb(1'b0, 12'h004, 32'h0, {tx_exp[31:3], 1'b1, tx_exp[1:0]}, 32'hffffffff);
            lose_sig <= 1'b0;
            n = 0;
            while (signal_absent_flag_out !== 1'b0 && n < 300)
            begin
                @(posedge presc_clk_in);
                n++;
            end
            cmp_rng(n, 0, 299);
            @(posedge clk_in);
        end
        end_of_test();
    end
endmodule
